/* pkg/hbp_defs.svh */
`ifndef HBP_DEFS_SVH
`define HBP_DEFS_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define HBP_ADDR_W        3
`define HBP_DATA_W        8
`define HBP_CHANNELS      2
`define HBP_FIFO_DEPTH    128
`define HBP_BUS_IDLE      8'hff

// ----------------------------------------------------------------
// Register offsets and fields inside a channel
// ----------------------------------------------------------------
`define HBP_REG_DATA      3'h0
`define HBP_REG_MODEM     3'h4
`define HBP_MCR_IRQ_BIT   3
`define HBP_REG_RESET     8'h00

// ----------------------------------------------------------------
// Host strobe timing, in ref_clk cycles
// ----------------------------------------------------------------
`define HBP_SETUP_CYC     4'h2
`define HBP_STROBE_CYC    4'h8
`define HBP_RECOVER_CYC   4'h6
`define HBP_CNT_ONE       4'h1
`define HBP_CNT_ZERO      4'h0

`endif

/* pkg/hbp_pkg.sv */
`include "hbp_defs.svh"
`default_nettype none
package hbp_pkg;

  typedef logic [`HBP_DATA_W-1:0] byte_t;
  typedef logic [`HBP_ADDR_W-1:0] reg_addr_t;

  typedef enum logic [3:0] {
    HS_IDLE    = 4'b0001,
    HS_SETUP   = 4'b0010,
    HS_STROBE  = 4'b0100,
    HS_RECOVER = 4'b1000
  } host_state_t;

endpackage
`default_nettype wire

/* pkg/host_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface host_bus_if;
  logic [2:0] addr;
  logic [7:0] host_data;
  logic       host_data_oe;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  logic [7:0] data_bus;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic       chan0_select_n;
  logic       chan1_select_n;
  logic       chan0_irq_out;
  logic       chan0_irq_oe;
  logic       chan1_irq_out;
  logic       chan1_irq_oe;
  logic       chan0_gp_out_n;
  logic       chan1_gp_out_n;
  logic       chan0_tx_ready_n;
  logic       chan0_rx_ready_n;
  logic       chan1_tx_ready_n;
  logic       chan1_rx_ready_n;

  // Resolved data lines; an undriven bus floats high through pull-ups
  assign data_bus = dev_data_oe  ? dev_data  :
                    host_data_oe ? host_data : 8'hff;

  modport dev (
    input  addr, data_bus, read_strobe_n, write_strobe_n,
    input  chan0_select_n, chan1_select_n,
    output dev_data, dev_data_oe,
    output chan0_irq_out, chan0_irq_oe, chan1_irq_out, chan1_irq_oe,
    output chan0_gp_out_n, chan1_gp_out_n,
    output chan0_tx_ready_n, chan0_rx_ready_n,
    output chan1_tx_ready_n, chan1_rx_ready_n
  );

  modport host (
    output addr, host_data, host_data_oe, read_strobe_n, write_strobe_n,
    output chan0_select_n, chan1_select_n,
    input  data_bus,
    input  chan0_irq_out, chan0_irq_oe, chan1_irq_out, chan1_irq_oe,
    input  chan0_gp_out_n, chan1_gp_out_n,
    input  chan0_tx_ready_n, chan0_rx_ready_n,
    input  chan1_tx_ready_n, chan1_rx_ready_n
  );
endinterface
`default_nettype wire

/* rtl/uart_port_dev.sv */
// What this block does
// - Three address lines pick the channel register
// - Eight-bit bidirectional data, host writes, device reads
// - Read strobe fall fetches byte, host takes it
// - Write strobe rise stores bus byte in register
// - First channel select gives first channel bus
// - Second channel select gives second channel bus
// - Control bit set: first irq driven, gp low
// - Control bit clear: first irq floats, gp high
// - Second irq and gp follow its bit
// - Transmit ready low per channel from FIFO
// - First channel receive ready low from FIFO
// - Each channel has 128-byte transmit, receive FIFOs
// - Second channel receive ready low from FIFO
`include "hbp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_port_dev
  import hbp_pkg::*;
#(
  parameter int DEPTH = `HBP_FIFO_DEPTH
) (
  input  wire logic   ref_clk,
  input  wire logic   rst,
  host_bus_if.dev     bus
);

  localparam int PW = $clog2(DEPTH);
  localparam int NC = `HBP_CHANNELS;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Stage one feeds stage two only; everything else reads stage two.
  logic [3:0]  ctl_m_q, ctl_s_q;
  reg_addr_t   addr_m_q, addr_s_q;
  byte_t       data_m_q, data_s_q;
  logic        rd_prev_q, wr_prev_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl_m_q   <= 4'hf;
      ctl_s_q   <= 4'hf;
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
    end else begin
      ctl_m_q   <= {bus.chan1_select_n, bus.chan0_select_n,
                    bus.write_strobe_n, bus.read_strobe_n};
      ctl_s_q   <= ctl_m_q;
      rd_prev_q <= ctl_s_q[0];
      wr_prev_q <= ctl_s_q[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    addr_m_q <= bus.addr;
    addr_s_q <= addr_m_q;
    data_m_q <= bus.data_bus;
    data_s_q <= data_m_q;
  end

  // ----------------------------------------------------------------
  // Strobe edges and channel selection
  // ----------------------------------------------------------------
  wire         rd_s    = ctl_s_q[0];
  wire         wr_s    = ctl_s_q[1];
  wire [1:0]   cs_n_s  = ctl_s_q[3:2];
  wire         rd_fall = rd_prev_q & ~rd_s;
  wire         rd_rise = ~rd_prev_q & rd_s;
  wire         wr_fall = wr_prev_q & ~wr_s;
  wire         wr_rise = ~wr_prev_q & wr_s;
  // Both selects low at once is a host fault; neither channel answers
  wire         one_sel = cs_n_s[0] ^ cs_n_s[1];
  wire [1:0]   sel     = ~cs_n_s & {2{one_sel}};
  wire         rd_hit  = rd_fall & (|sel);

  logic [1:0]  wr_sel_q;
  reg_addr_t   wr_addr_q;
  logic        rd_chan_q;
  logic        oe_q;
  byte_t       dout_q;
  byte_t       rd_byte [NC];

  // Address and channel are latched at the write strobe's fall so that
  // late address changes cannot redirect the store
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_sel_q  <= 2'h0;
      wr_addr_q <= `HBP_REG_DATA;
    end else if (wr_fall) begin
      wr_sel_q  <= sel;
      wr_addr_q <= addr_s_q;
    end
  end

  // ----------------------------------------------------------------
  // Read data driver
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      oe_q      <= 1'b0;
      dout_q    <= `HBP_REG_RESET;
      rd_chan_q <= 1'b0;
    end else if (rd_hit) begin
      oe_q      <= 1'b1;
      rd_chan_q <= sel[1];
      dout_q    <= sel[1] ? rd_byte[1] : rd_byte[0];
    end else if (rd_rise || !one_sel) begin
      oe_q      <= 1'b0;
    end
  end

  assign bus.dev_data    = dout_q;
  assign bus.dev_data_oe = oe_q;

  // ----------------------------------------------------------------
  // Per-channel registers and FIFOs
  // ----------------------------------------------------------------
  // With the serial side absent, the transmit FIFO drains into the
  // receive FIFO of the same channel, one byte a cycle, as a loopback.
  logic [NC-1:0] irq_q, irq_oe_q, gp_n_q, txr_n_q, rxr_n_q;

  for (genvar c = 0; c < NC; c++) begin : g_chan
    byte_t          regs_q  [8];
    byte_t          tx_mem_q [DEPTH];
    byte_t          rx_mem_q [DEPTH];
    logic [PW-1:0]  tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
    logic [PW:0]    tx_cnt_q, rx_cnt_q;

    wire       tx_full  = (tx_cnt_q == (PW+1)'(DEPTH));
    wire       rx_full  = (rx_cnt_q == (PW+1)'(DEPTH));
    wire       tx_any   = (tx_cnt_q != '0);
    wire       rx_any   = (rx_cnt_q != '0);
    wire       wr_hit   = wr_rise & wr_sel_q[c];
    wire       wr_data  = wr_hit & (wr_addr_q == `HBP_REG_DATA);
    wire       wr_reg   = wr_hit & (wr_addr_q != `HBP_REG_DATA);
    wire       rd_data  = rd_fall & sel[c] &
                          (addr_s_q == `HBP_REG_DATA);
    // A byte written to a full transmit FIFO is dropped
    wire       tx_push  = wr_data & ~tx_full;
    wire       move     = tx_any & ~rx_full;
    wire       rx_pop   = rd_data & rx_any;
    wire       irq_en   = regs_q[`HBP_REG_MODEM][`HBP_MCR_IRQ_BIT];
    wire [PW:0] tx_cnt_d = tx_cnt_q + (PW+1)'(tx_push)
                                    - (PW+1)'(move);
    wire [PW:0] rx_cnt_d = rx_cnt_q + (PW+1)'(move)
                                    - (PW+1)'(rx_pop);

    // Reading an empty receive FIFO returns the stale entry at the read pointer
    assign rd_byte[c] = (addr_s_q == `HBP_REG_DATA) ?
                        rx_mem_q[rx_rp_q] : regs_q[addr_s_q];

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        for (int i = 0; i < 8; i++) regs_q[i] <= `HBP_REG_RESET;
      end else if (wr_reg) begin
        regs_q[wr_addr_q] <= data_s_q;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (tx_push) tx_mem_q[tx_wp_q] <= data_s_q;
      if (move)    rx_mem_q[rx_wp_q] <= tx_mem_q[tx_rp_q];
    end

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        tx_wp_q  <= '0;
        tx_rp_q  <= '0;
        rx_wp_q  <= '0;
        rx_rp_q  <= '0;
        tx_cnt_q <= '0;
        rx_cnt_q <= '0;
      end else begin
        tx_wp_q  <= tx_wp_q + PW'(tx_push);
        tx_rp_q  <= tx_rp_q + PW'(move);
        rx_wp_q  <= rx_wp_q + PW'(move);
        rx_rp_q  <= rx_rp_q + PW'(rx_pop);
        tx_cnt_q <= tx_cnt_d;
        rx_cnt_q <= rx_cnt_d;
      end
    end

    // Pin flops; ready levels follow next-cycle fill so they never lag
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        irq_q[c]    <= 1'b0;
        irq_oe_q[c] <= 1'b0;
        gp_n_q[c]   <= 1'b1;
        txr_n_q[c]  <= 1'b0;
        rxr_n_q[c]  <= 1'b1;
      end else begin
        irq_q[c]    <= (rx_cnt_d != '0);
        irq_oe_q[c] <= irq_en;
        gp_n_q[c]   <= ~irq_en;
        txr_n_q[c]  <= (tx_cnt_d == (PW+1)'(DEPTH));
        rxr_n_q[c]  <= (rx_cnt_d == '0);
      end
    end
  end

  // ----------------------------------------------------------------
  // Status pins
  // ----------------------------------------------------------------
  assign bus.chan0_irq_out    = irq_q[0];
  assign bus.chan0_irq_oe     = irq_oe_q[0];
  assign bus.chan1_irq_out    = irq_q[1];
  assign bus.chan1_irq_oe     = irq_oe_q[1];
  assign bus.chan0_gp_out_n   = gp_n_q[0];
  assign bus.chan1_gp_out_n   = gp_n_q[1];
  assign bus.chan0_tx_ready_n = txr_n_q[0];
  assign bus.chan1_tx_ready_n = txr_n_q[1];
  assign bus.chan0_rx_ready_n = rxr_n_q[0];
  assign bus.chan1_rx_ready_n = rxr_n_q[1];

endmodule
`default_nettype wire

/* rtl/uart_port_host.sv */
`include "hbp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_port_host
  import hbp_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   rst,
  host_bus_if.host    bus,
  input  wire logic   req_valid,
  input  wire logic   req_write,
  input  wire logic   req_chan,
  input  wire logic [2:0] req_addr,
  input  wire logic [7:0] req_wdata,
  output logic        req_ready,
  output logic        rsp_valid,
  output logic [7:0]  rsp_rdata,
  output logic [1:0]  irq_active,
  output logic [1:0]  tx_ready,
  output logic [1:0]  rx_ready
);

  host_state_t st_q;
  logic [3:0]  cnt_q;
  logic        wr_q, chan_q, rd_n_q, wr_n_q, oe_q, rsp_q;
  logic [1:0]  cs_n_q;
  reg_addr_t   addr_q;
  byte_t       wdata_q, rdata_q, bus_m_q, bus_s_q;
  logic [5:0]  st_m_q, st_s_q;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    bus_m_q <= bus.data_bus;
    bus_s_q <= bus_m_q;
    st_m_q  <= {bus.chan1_irq_out & bus.chan1_irq_oe,
                bus.chan0_irq_out & bus.chan0_irq_oe,
                ~bus.chan1_tx_ready_n, ~bus.chan0_tx_ready_n,
                ~bus.chan1_rx_ready_n, ~bus.chan0_rx_ready_n};
    st_s_q  <= st_m_q;
  end

  wire cnt_done = (cnt_q == `HBP_CNT_ONE);

  // ----------------------------------------------------------------
  // Strobe sequencer
  // ----------------------------------------------------------------
  // Select and address are held across the whole strobe and recovery,
  // so the device sees them steady on both strobe edges
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q    <= HS_IDLE;
      cnt_q   <= `HBP_CNT_ZERO;
      cs_n_q  <= 2'h3;
      rd_n_q  <= 1'b1;
      wr_n_q  <= 1'b1;
      oe_q    <= 1'b0;
      rsp_q   <= 1'b0;
      wr_q    <= 1'b0;
      chan_q  <= 1'b0;
      addr_q  <= `HBP_REG_DATA;
      wdata_q <= `HBP_REG_RESET;
      rdata_q <= `HBP_REG_RESET;
    end else begin
      rsp_q <= 1'b0;
      case (st_q)
        HS_IDLE: begin
          if (req_valid) begin
            wr_q    <= req_write;
            chan_q  <= req_chan;
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
            oe_q    <= req_write;
            cs_n_q  <= req_chan ? 2'h1 : 2'h2;
            cnt_q   <= `HBP_SETUP_CYC;
            st_q    <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          cnt_q <= cnt_q - `HBP_CNT_ONE;
          if (cnt_done) begin
            rd_n_q <= wr_q;
            wr_n_q <= ~wr_q;
            cnt_q  <= `HBP_STROBE_CYC;
            st_q   <= HS_STROBE;
          end
        end
        HS_STROBE: begin
          cnt_q <= cnt_q - `HBP_CNT_ONE;
          if (cnt_done) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            if (!wr_q) rdata_q <= bus_s_q;
            cnt_q  <= `HBP_RECOVER_CYC;
            st_q   <= HS_RECOVER;
          end
        end
        HS_RECOVER: begin
          cnt_q <= cnt_q - `HBP_CNT_ONE;
          if (cnt_done) begin
            cs_n_q <= 2'h3;
            oe_q   <= 1'b0;
            rsp_q  <= 1'b1;
            st_q   <= HS_IDLE;
          end
        end
        default: begin
          st_q <= HS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic        rdy_q;
  logic [5:0]  stat_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdy_q  <= 1'b0;
      stat_q <= 6'h00;
    end else begin
      rdy_q  <= (st_q == HS_IDLE) & ~req_valid;
      stat_q <= st_s_q;
    end
  end

  assign bus.addr           = addr_q;
  assign bus.host_data      = wdata_q;
  assign bus.host_data_oe   = oe_q;
  assign bus.read_strobe_n  = rd_n_q;
  assign bus.write_strobe_n = wr_n_q;
  assign bus.chan0_select_n = cs_n_q[0];
  assign bus.chan1_select_n = cs_n_q[1];
  assign req_ready          = rdy_q;
  assign rsp_valid          = rsp_q;
  assign rsp_rdata          = rdata_q;
  assign irq_active         = stat_q[5:4];
  assign tx_ready           = stat_q[3:2];
  assign rx_ready           = stat_q[1:0];

endmodule
`default_nettype wire

/* verification/dual_channel_host_bus_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_channel_host_bus_port_tb;
  import hbp_pkg::*;
  localparam int DEP = 4;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       req_valid = 1'b0;
  logic       req_write = 1'b0;
  logic       req_chan = 1'b0;
  reg_addr_t  req_addr = 3'h0;
  byte_t      req_wdata = 8'h00;
  logic       req_ready;
  logic       rsp_valid;
  byte_t      rsp_rdata;
  logic [1:0] irq_active;
  logic [1:0] tx_ready;
  logic [1:0] rx_ready;
  byte_t      rd;
  int         fail_count = 0;
  int         checks_done = 0;
  int         k;

  host_bus_if bus ();
  always #5 ref_clk = ~ref_clk;

  // Short FIFOs so that filling both of them stays quick
  uart_port_dev #(.DEPTH(DEP)) uart_port_dev_inst (
    .ref_clk(ref_clk), .rst(rst), .bus(bus));
  uart_port_host uart_port_host_inst (
    .ref_clk(ref_clk), .rst(rst), .bus(bus), .req_valid(req_valid),
    .req_write(req_write), .req_chan(req_chan), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .irq_active(irq_active),
    .tx_ready(tx_ready), .rx_ready(rx_ready));
  host_bus_chk host_bus_chk_inst (
    .ref_clk(ref_clk), .rst(rst), .host_data_oe(bus.host_data_oe),
    .dev_data_oe(bus.dev_data_oe), .dev_data(bus.dev_data),
    .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
    .chan0_select_n(bus.chan0_select_n),
    .chan1_select_n(bus.chan1_select_n),
    .chan0_irq_oe(bus.chan0_irq_oe), .chan1_irq_oe(bus.chan1_irq_oe),
    .chan0_gp_out_n(bus.chan0_gp_out_n),
    .chan1_gp_out_n(bus.chan1_gp_out_n));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    fail_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  // Called just after an edge; req_valid drops once the request is taken
  task automatic xfer(input logic w, input logic c, input reg_addr_t a,
                      input byte_t d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 50) fail("request not taken");
    req_valid = 1'b1;
    req_write = w;
    req_chan = c;
    req_addr = a;
    req_wdata = d;
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 50) fail("no response");
    rd = rsp_rdata;
  endtask

  task automatic rd_chk(input logic c, input reg_addr_t a, input byte_t e);
    xfer(1'b0, c, a, 8'h00);
    checks_done++;
    if (rd !== e) fail("read data");
  endtask

  // Status crosses synchronisers, so poll under a bound
  task automatic expect_st(input logic [1:0] oe, rx, tx);
    int n;
    logic ok;
    ok = 1'b0;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge ref_clk);
      #1;
      ok = ({bus.chan1_irq_oe, bus.chan0_irq_oe} === oe)
        && ({bus.chan1_gp_out_n, bus.chan0_gp_out_n} === ~oe)
        && (rx_ready === rx) && (tx_ready === tx)
        && ((irq_active & oe) === (rx & oe));
    end
    checks_done++;
    if (!ok) fail("status pins");
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    expect_st(2'b00, 2'b00, 2'b11);
    $display("reset test done");
    for (k = 1; k < 8; k++) begin
      if (k != 4) begin
        xfer(1'b1, 1'b0, reg_addr_t'(k), byte_t'(8'h01 << k));
        xfer(1'b1, 1'b1, reg_addr_t'(k), ~byte_t'(8'h01 << k));
      end
    end
    for (k = 1; k < 8; k++) begin
      if (k != 4) begin
        rd_chk(1'b0, reg_addr_t'(k), byte_t'(8'h01 << k));
        rd_chk(1'b1, reg_addr_t'(k), ~byte_t'(8'h01 << k));
      end
    end
    $display("register test done");
    xfer(1'b1, 1'b0, 3'h4, 8'h08);
    expect_st(2'b01, 2'b00, 2'b11);
    xfer(1'b1, 1'b1, 3'h4, 8'h08);
    expect_st(2'b11, 2'b00, 2'b11);
    rd_chk(1'b0, 3'h4, 8'h08);
    xfer(1'b1, 1'b0, 3'h4, 8'h00);
    expect_st(2'b10, 2'b00, 2'b11);
    $display("irq mode test done");
    xfer(1'b1, 1'b1, 3'h0, 8'h3c);
    expect_st(2'b10, 2'b10, 2'b11);
    rd_chk(1'b1, 3'h0, 8'h3c);
    expect_st(2'b10, 2'b00, 2'b11);
    $display("loopback test done");
    // Receive side fills first, then transmit; the last byte is dropped
    for (k = 0; k < 2 * DEP + 1; k++) begin
      xfer(1'b1, 1'b0, 3'h0, byte_t'(8'h40 + k));
    end
    expect_st(2'b10, 2'b01, 2'b10);
    for (k = 0; k < 2 * DEP; k++) begin
      rd_chk(1'b0, 3'h0, byte_t'(8'h40 + k));
    end
    expect_st(2'b10, 2'b00, 2'b11);
    $display("fifo fill test done");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail("watchdog expired");
    report_and_stop();
  end
endmodule
`default_nettype wire

/* verification/host_bus_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module host_bus_chk (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       host_data_oe,
  input wire logic       dev_data_oe,
  input wire logic [7:0] dev_data,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       chan0_select_n,
  input wire logic       chan1_select_n,
  input wire logic       chan0_irq_oe,
  input wire logic       chan1_irq_oe,
  input wire logic       chan0_gp_out_n,
  input wire logic       chan1_gp_out_n
);
  // ----------------------------------------------------------------
  // Bus ownership and pin relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Exactly one channel selected; both low counts as no selection
  wire logic one_sel;
  assign one_sel = chan0_select_n ^ chan1_select_n;

  a_no_contention: assert property (dev_data_oe |-> !host_data_oe)
    else $error("both ends drive the data lines");
  a_write_no_drive: assert property (dev_data_oe |-> write_strobe_n)
    else $error("device drives data during a write strobe");
  a_select_gates: assert property (dev_data_oe |-> one_sel)
    else $error("device drives data without a single select");
  a_idle_quiet: assert property (!one_sel |-> !dev_data_oe)
    else $error("device drives data while not selected");
  a_read_answer: assert property (
    $fell(read_strobe_n) && one_sel |-> ##[1:6] dev_data_oe)
    else $error("no read data after read strobe fall");
  a_read_release: assert property (
    $rose(read_strobe_n) |-> ##[1:6] !dev_data_oe)
    else $error("read data not released after strobe rise");
  a_read_hold: assert property (
    dev_data_oe && $past(dev_data_oe) |-> $stable(dev_data))
    else $error("read data changed while driven");
  a_irq_gp0: assert property (chan0_irq_oe == !chan0_gp_out_n)
    else $error("channel 0 irq drive and gp output disagree");
  a_irq_gp1: assert property (chan1_irq_oe == !chan1_gp_out_n)
    else $error("channel 1 irq drive and gp output disagree");

  c_read: cover property ($rose(dev_data_oe));
  c_write1: cover property ($fell(write_strobe_n) && !chan1_select_n);
  c_irq1_on: cover property ($rose(chan1_irq_oe));
endmodule
`default_nettype wire
